// >>> design/lrs_defs.vh
// Register map, field layout, defaults and timing for the regulator sequencing block
`ifndef LRS_DEFS_VH
`define LRS_DEFS_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define LRS_IDX_C_CTL 10'h0ce
`define LRS_IDX_C_FS 10'h0cf
`define LRS_IDX_C_HIB 10'h0d0
`define LRS_IDX_D_CTL 10'h0d1
`define LRS_IDX_D_FS 10'h0d2
`define LRS_IDX_D_HIB 10'h0d3
`define LRS_IDX_SYS 10'h0e0
`define LRS_IDX_STAT 10'h0e1

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define LRS_F_ACT 15:14
`define LRS_F_ACT_SYS 15
`define LRS_F_ENSLOT 13:10
`define LRS_F_SDSLOT 9:6
`define LRS_F_HMODE 13:12
`define LRS_F_HTRIG 9:8
`define LRS_F_VCODE 4:0
`define LRS_F_SWI 14
`define LRS_F_FLOAT 10
`define LRS_F_UPREQ 0
`define LRS_F_DNREQ 1
`define LRS_F_HIBBIT 2

// ----------------------------------------------------------------
// Writable masks and defaults
// ----------------------------------------------------------------
`define LRS_MASK_FS 16'hffc0
`define LRS_MASK_HIB 16'h331f
`define LRS_MASK_CTL 16'h441f
`define LRS_DEF_FS 16'h0000
`define LRS_DEF_HIB 16'h001c
`define LRS_DEF_CTL 16'h001b

// ----------------------------------------------------------------
// Codes
// ----------------------------------------------------------------
`define LRS_ACT_REG 2'b01
`define LRS_SLOT_NONE 4'h0
`define LRS_SLOT_FIRST 4'h1
`define LRS_SLOT_LAST 4'he
`define LRS_SLOT_ACTIVE 4'hf
`define LRS_HMODE_OFF 2'b01
`define LRS_TRIG_BIT 2'b00
`define LRS_TRIG_P1 2'b01
`define LRS_TRIG_P2 2'b10

// ----------------------------------------------------------------
// Voltage encoding in millivolts
// ----------------------------------------------------------------
`define LRS_MV_LO_BASE 12'h384
`define LRS_MV_LO_STEP 12'h032
`define LRS_MV_HI_BASE 12'h708
`define LRS_MV_HI_STEP 12'h064

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define LRS_CLK_NS 25
`define LRS_SLOT_NS 2000000
`define LRS_SLOT_CYCLES (`LRS_SLOT_NS / `LRS_CLK_NS)

`endif

// >>> design/lrs_sync.v
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module lrs_sync #(
  parameter W = 1
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Data
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= {W{1'b0}};
      q <= {W{1'b0}};
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule // lrs_sync

// >>> design/lrs_seq.v
// Time-slot counter for power-up and power-down ordering
`timescale 1ns/1ps
`include "lrs_defs.vh"
module lrs_seq #(
  parameter [23:0] SLOT_CYCLES = `LRS_SLOT_CYCLES
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Control
  input wire start,
  input wire stop,
  // Slot progress
  output reg [3:0] slot,
  output reg tick,
  output reg done
);
  reg run_r;
  reg [23:0] cnt_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_r <= 1'b0;
      cnt_r <= 24'h00_0000;
      slot <= `LRS_SLOT_NONE;
      tick <= 1'b0;
      done <= 1'b0;
    end else begin
      tick <= 1'b0;
      done <= 1'b0;
      if (stop) begin
        run_r <= 1'b0;
        slot <= `LRS_SLOT_NONE;
      end else if (start) begin
        run_r <= 1'b1;
        cnt_r <= 24'h00_0000;
        slot <= `LRS_SLOT_FIRST;
        tick <= 1'b1;
      end else if (run_r) begin
        if (cnt_r == SLOT_CYCLES - 24'h00_0001) begin
          cnt_r <= 24'h00_0000;
          if (slot == `LRS_SLOT_LAST) begin
            run_r <= 1'b0;
            slot <= `LRS_SLOT_NONE;
            done <= 1'b1;
          end else begin
            slot <= slot + 4'h1;
            tick <= 1'b1;
          end
        end else begin
          cnt_r <= cnt_r + 24'h00_0001;
        end
      end
    end
  end
endmodule // lrs_seq

// >>> design/lrs_top.v
// Sequencing, fault and hibernate control for regulators C and D with APB registers
//
// Summary of operation
// - Fault raises interrupt; action field picks extra step.
// - Action codes 10 and 11 shut system down too.
// - Startup slot 0 stays off, 1-14 numbered.
// - Startup code 15 enables on entering ACTIVE.
// - Fourteen slots for both startup and shutdown.
// - Shutdown slot 0/15 means off at OFF.
// - Hibernate uses image voltage or disables output.
// - Hibernate source: register bit or pin 1-3.
// - Voltage code: 50 mV then 100 mV steps.
// - Normal code counts only outside hibernate and switch mode.
// - Switch mode ignores the voltage code.
// - Disabled output discharged unless float bit set.
// - All regulators off forces discharge of all.
// - System shutdown restores fixed field defaults.
`timescale 1ns/1ps
`include "lrs_defs.vh"
module lrs_top #(
  parameter [23:0] SLOT_CYCLES = `LRS_SLOT_CYCLES
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Pins
  input wire low_power_pin_1,
  input wire low_power_pin_2,
  input wire low_power_pin_3,
  input wire fault_c,
  input wire fault_d,
  input wire others_off,
  // Regulator C
  output reg reg_c_on,
  output reg reg_c_discharge,
  output reg reg_c_switch,
  output reg [11:0] reg_c_mv,
  output reg reg_c_irq,
  // Regulator D
  output reg reg_d_on,
  output reg reg_d_discharge,
  output reg reg_d_switch,
  output reg [11:0] reg_d_mv,
  output reg reg_d_irq,
  // System
  output reg sys_shutdown
);
  localparam [1:0] ST_OFF = 2'b00;
  localparam [1:0] ST_UP = 2'b01;
  localparam [1:0] ST_ACT = 2'b10;
  localparam [1:0] ST_DOWN = 2'b11;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function [11:0] lrs_mv;
    input [4:0] c;
    lrs_mv = c[4] ? `LRS_MV_HI_BASE + ({8'h00, c[3:0]} * `LRS_MV_HI_STEP) :
                    `LRS_MV_LO_BASE + ({8'h00, c[3:0]} * `LRS_MV_LO_STEP);
  endfunction

  function lrs_hib_src;
    input [1:0] trig;
    input hib_bit;
    input [2:0] pins;
    begin
      case (trig)
        `LRS_TRIG_BIT: lrs_hib_src = hib_bit;
        `LRS_TRIG_P1: lrs_hib_src = pins[0];
        `LRS_TRIG_P2: lrs_hib_src = pins[1];
        default: lrs_hib_src = pins[2];
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  wire [2:0] lp_s;
  wire [2:0] flt_s;
  reg [1:0] flt_d_r;

  lrs_sync #(.W(3)) u_lp_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({low_power_pin_3, low_power_pin_2, low_power_pin_1}),
    .q(lp_s)
  );

  lrs_sync #(.W(3)) u_flt_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({others_off, fault_d, fault_c}),
    .q(flt_s)
  );

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  reg [15:0] c_ctl_r, c_fs_r, c_hib_r, d_ctl_r, d_fs_r, d_hib_r;
  reg hib_bit_r;
  reg [1:0] state_r;
  reg en_c_r, en_d_r;
  reg up_req_r, dn_req_r;

  wire [1:0] flt_rise = flt_s[1:0] & ~flt_d_r;
  wire act_c_sys = flt_rise[0] & c_fs_r[`LRS_F_ACT_SYS];
  wire act_d_sys = flt_rise[1] & d_fs_r[`LRS_F_ACT_SYS];
  wire act_c_reg = flt_rise[0] & (c_fs_r[`LRS_F_ACT] == `LRS_ACT_REG);
  wire act_d_reg = flt_rise[1] & (d_fs_r[`LRS_F_ACT] == `LRS_ACT_REG);
  wire sys_sd = act_c_sys | act_d_sys;

  // ----------------------------------------------------------------
  // Slot sequencer
  // ----------------------------------------------------------------
  wire [3:0] slot;
  wire tick;
  wire done;
  wire seq_start = (state_r == ST_OFF && up_req_r) || (state_r == ST_ACT && dn_req_r);

  lrs_seq #(.SLOT_CYCLES(SLOT_CYCLES)) u_seq (
    .pclk(pclk),
    .presetn(presetn),
    .start(seq_start & ~sys_sd),
    .stop(sys_sd),
    .slot(slot),
    .tick(tick),
    .done(done)
  );

  // ----------------------------------------------------------------
  // APB access
  // ----------------------------------------------------------------
  wire [9:0] idx = paddr[11:2];
  wire wr_en = psel & penable & pready & pwrite;
  reg hit;
  reg [31:0] rd_nxt;

  always @* begin
    hit = (paddr[1:0] == 2'b00);
    rd_nxt = 32'h0000_0000;
    case (idx)
      `LRS_IDX_C_CTL: rd_nxt = {16'h0000, c_ctl_r};
      `LRS_IDX_C_FS: rd_nxt = {16'h0000, c_fs_r};
      `LRS_IDX_C_HIB: rd_nxt = {16'h0000, c_hib_r};
      `LRS_IDX_D_CTL: rd_nxt = {16'h0000, d_ctl_r};
      `LRS_IDX_D_FS: rd_nxt = {16'h0000, d_fs_r};
      `LRS_IDX_D_HIB: rd_nxt = {16'h0000, d_hib_r};
      `LRS_IDX_SYS: rd_nxt = {29'h0000_0000, hib_bit_r, dn_req_r, up_req_r};
      `LRS_IDX_STAT: rd_nxt = {22'h00_0000, slot, reg_d_discharge, reg_c_discharge,
                               reg_d_on, reg_c_on, state_r};
      default: hit = 1'b0;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit;
      if (psel & ~penable & ~pwrite & hit) begin
        prdata <= rd_nxt;
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers, reloaded on system shutdown
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c_ctl_r <= `LRS_DEF_CTL;
      c_fs_r <= `LRS_DEF_FS;
      c_hib_r <= `LRS_DEF_HIB;
      d_ctl_r <= `LRS_DEF_CTL;
      d_fs_r <= `LRS_DEF_FS;
      d_hib_r <= `LRS_DEF_HIB;
      hib_bit_r <= 1'b0;
      up_req_r <= 1'b0;
      dn_req_r <= 1'b0;
    end else if (sys_sd) begin
      c_ctl_r <= `LRS_DEF_CTL;
      c_fs_r <= `LRS_DEF_FS;
      c_hib_r <= `LRS_DEF_HIB;
      d_ctl_r <= `LRS_DEF_CTL;
      d_fs_r <= `LRS_DEF_FS;
      d_hib_r <= `LRS_DEF_HIB;
      hib_bit_r <= 1'b0;
      up_req_r <= 1'b0;
      dn_req_r <= 1'b0;
    end else begin
      if (seq_start) begin
        up_req_r <= 1'b0;
        dn_req_r <= 1'b0;
      end
      if (wr_en && paddr[1:0] == 2'b00) begin
        case (idx)
          `LRS_IDX_C_CTL: c_ctl_r <= pwdata[15:0] & `LRS_MASK_CTL;
          `LRS_IDX_C_FS: c_fs_r <= pwdata[15:0] & `LRS_MASK_FS;
          `LRS_IDX_C_HIB: c_hib_r <= pwdata[15:0] & `LRS_MASK_HIB;
          `LRS_IDX_D_CTL: d_ctl_r <= pwdata[15:0] & `LRS_MASK_CTL;
          `LRS_IDX_D_FS: d_fs_r <= pwdata[15:0] & `LRS_MASK_FS;
          `LRS_IDX_D_HIB: d_hib_r <= pwdata[15:0] & `LRS_MASK_HIB;
          `LRS_IDX_SYS: begin
            hib_bit_r <= pwdata[`LRS_F_HIBBIT];
            if (pwdata[`LRS_F_UPREQ]) begin
              up_req_r <= 1'b1;
            end
            if (pwdata[`LRS_F_DNREQ]) begin
              dn_req_r <= 1'b1;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Power state machine and enables
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_OFF;
      en_c_r <= 1'b0;
      en_d_r <= 1'b0;
      flt_d_r <= 2'b00;
      reg_c_irq <= 1'b0;
      reg_d_irq <= 1'b0;
      sys_shutdown <= 1'b0;
    end else begin
      flt_d_r <= flt_s[1:0];
      reg_c_irq <= flt_rise[0];
      reg_d_irq <= flt_rise[1];
      sys_shutdown <= sys_sd;
      if (sys_sd) begin
        state_r <= ST_OFF;
        en_c_r <= 1'b0;
        en_d_r <= 1'b0;
      end else begin
        case (state_r)
          ST_OFF: begin
            if (up_req_r) begin
              state_r <= ST_UP;
            end
          end
          ST_UP: begin
            if (tick && c_fs_r[`LRS_F_ENSLOT] == slot) begin
              en_c_r <= 1'b1;
            end
            if (tick && d_fs_r[`LRS_F_ENSLOT] == slot) begin
              en_d_r <= 1'b1;
            end
            if (done) begin
              state_r <= ST_ACT;
              if (c_fs_r[`LRS_F_ENSLOT] == `LRS_SLOT_ACTIVE) begin
                en_c_r <= 1'b1;
              end
              if (d_fs_r[`LRS_F_ENSLOT] == `LRS_SLOT_ACTIVE) begin
                en_d_r <= 1'b1;
              end
            end
          end
          ST_ACT: begin
            if (dn_req_r) begin
              state_r <= ST_DOWN;
            end
          end
          ST_DOWN: begin
            if (tick && c_fs_r[`LRS_F_SDSLOT] == slot) begin
              en_c_r <= 1'b0;
            end
            if (tick && d_fs_r[`LRS_F_SDSLOT] == slot) begin
              en_d_r <= 1'b0;
            end
            if (done) begin
              state_r <= ST_OFF;
              en_c_r <= 1'b0;
              en_d_r <= 1'b0;
            end
          end
          default: state_r <= ST_OFF;
        endcase
        if (act_c_reg) begin
          en_c_r <= 1'b0;
        end
        if (act_d_reg) begin
          en_d_r <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Hibernate, voltage and discharge outputs
  // ----------------------------------------------------------------
  wire hib_c = (state_r == ST_ACT) & lrs_hib_src(c_hib_r[`LRS_F_HTRIG], hib_bit_r, lp_s);
  wire hib_d = (state_r == ST_ACT) & lrs_hib_src(d_hib_r[`LRS_F_HTRIG], hib_bit_r, lp_s);
  wire on_c = en_c_r & ~(hib_c & c_hib_r[`LRS_F_HMODE] == `LRS_HMODE_OFF);
  wire on_d = en_d_r & ~(hib_d & d_hib_r[`LRS_F_HMODE] == `LRS_HMODE_OFF);
  wire all_off = ~on_c & ~on_d & flt_s[2];
  wire [4:0] code_c = hib_c ? c_hib_r[`LRS_F_VCODE] : c_ctl_r[`LRS_F_VCODE];
  wire [4:0] code_d = hib_d ? d_hib_r[`LRS_F_VCODE] : d_ctl_r[`LRS_F_VCODE];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_c_on <= 1'b0;
      reg_d_on <= 1'b0;
      reg_c_discharge <= 1'b0;
      reg_d_discharge <= 1'b0;
      reg_c_switch <= 1'b0;
      reg_d_switch <= 1'b0;
      reg_c_mv <= 12'h000;
      reg_d_mv <= 12'h000;
    end else begin
      reg_c_on <= on_c;
      reg_d_on <= on_d;
      reg_c_discharge <= ~on_c & (~c_ctl_r[`LRS_F_FLOAT] | all_off);
      reg_d_discharge <= ~on_d & (~d_ctl_r[`LRS_F_FLOAT] | all_off);
      reg_c_switch <= c_ctl_r[`LRS_F_SWI];
      reg_d_switch <= d_ctl_r[`LRS_F_SWI];
      reg_c_mv <= c_ctl_r[`LRS_F_SWI] ? 12'h000 : lrs_mv(code_c);
      reg_d_mv <= d_ctl_r[`LRS_F_SWI] ? 12'h000 : lrs_mv(code_d);
    end
  end
endmodule // lrs_top

// >>> dv/lrs_top_properties.sv
// Port-level properties of the regulator sequencing block
`timescale 1ns/1ps
module lrs_top_properties #(
  parameter [23:0] SLOT_CYCLES = 24'h00_0004
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB
  input wire psel,
  input wire penable,
  input wire [11:0] paddr,
  input wire pready,
  input wire pslverr,
  // Pins and outputs
  input wire fault_c,
  input wire others_off,
  input wire reg_c_on,
  input wire reg_d_on,
  input wire reg_c_discharge,
  input wire reg_d_discharge,
  input wire reg_c_irq,
  input wire reg_d_switch,
  input wire [11:0] reg_c_mv,
  input wire [11:0] reg_d_mv,
  input wire sys_shutdown
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  property p_rdy_setup; psel && !penable |=> pready; endproperty
  a_rdy_setup: assert property (p_rdy_setup) else $error("no ready after setup");
  property p_rdy_pulse; pready |=> !pready; endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready longer than one cycle");
  property p_rdy_acc; pready |-> psel && penable; endproperty
  a_rdy_acc: assert property (p_rdy_acc) else $error("ready outside access phase");
  property p_err_mis; psel && !penable && (paddr[1:0] != 2'b00) |=> pslverr; endproperty
  a_err_mis: assert property (p_err_mis) else $error("misaligned access accepted");
  property p_err_rdy; pslverr |-> pready; endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("error without ready");
  // ----------------------------------------------------------------
  // Regulator behaviour
  // ----------------------------------------------------------------
  property p_irq_pulse; reg_c_irq |=> !reg_c_irq; endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("fault event longer than one cycle");
  property p_irq_cause; reg_c_irq |-> $past(fault_c, 2) || $past(fault_c, 3); endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("fault event without fault");
  property p_shut; sys_shutdown |-> ##[1:2] (!reg_c_on && !reg_d_on); endproperty
  a_shut: assert property (p_shut) else $error("regulators on after shutdown");
  property p_sw_mv; reg_d_switch |-> reg_d_mv == 12'h000; endproperty
  a_sw_mv: assert property (p_sw_mv) else $error("voltage target in switch mode");
  property p_mv_step;
    reg_c_mv != 12'h000 |-> (reg_c_mv >= 12'h384 && reg_c_mv <= 12'h672 && reg_c_mv % 50 == 0) ||
      (reg_c_mv >= 12'h708 && reg_c_mv <= 12'hce4 && reg_c_mv % 100 == 0);
  endproperty
  a_mv_step: assert property (p_mv_step) else $error("voltage off the code grid");
  property p_on_dis; reg_c_on [*2] |-> !reg_c_discharge; endproperty
  a_on_dis: assert property (p_on_dis) else $error("discharge while enabled");
  property p_all_off;
    (!reg_c_on && !reg_d_on && others_off) [*4] |-> reg_c_discharge && reg_d_discharge;
  endproperty
  a_all_off: assert property (p_all_off) else $error("no discharge with all off");
  c_irq: cover property (reg_c_irq);
  c_shut: cover property (sys_shutdown);
  c_err: cover property (pslverr);
  c_both: cover property (reg_c_on && reg_d_on);
endmodule // lrs_top_properties

// >>> dv/lrs_top_tb.sv
// Self-checking bench for the regulator sequencing block
`timescale 1ns/1ps
`include "lrs_defs.vh"
`define CHK(a, b, m) begin total_checks++; if ((a) !== (b)) begin errors++; $display("mismatch %0t %s", $time, m); end end
module lrs_top_tb;
  reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fc = 0, fd = 0, oo = 0;
  reg [11:0] paddr = 0;
  reg [31:0] pwdata = 0, rd, v;
  reg [2:0] lp = 0;
  reg e;
  wire [31:0] prdata;
  wire pready, pslverr, c_on, c_dis, c_sw, c_irq, d_on, d_dis, d_sw, d_irq, shut;
  wire [11:0] c_mv, d_mv;
  integer errors = 0, total_checks = 0, seed = 32'hf04d_290c, i, k, nirq = 0, nirqd = 0, nshut = 0;
  lrs_top #(.SLOT_CYCLES(24'h00_0004)) lrs_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .low_power_pin_1(lp[0]), .low_power_pin_2(lp[1]), .low_power_pin_3(lp[2]),
    .fault_c(fc), .fault_d(fd), .others_off(oo), .reg_c_on(c_on), .reg_c_discharge(c_dis),
    .reg_c_switch(c_sw), .reg_c_mv(c_mv), .reg_c_irq(c_irq), .reg_d_on(d_on), .reg_d_discharge(d_dis),
    .reg_d_switch(d_sw), .reg_d_mv(d_mv), .reg_d_irq(d_irq), .sys_shutdown(shut));
  initial forever #12.5 pclk = ~pclk;
  always @(posedge pclk) begin
    if (c_irq === 1'b1) nirq <= nirq + 1;
    if (d_irq === 1'b1) nirqd <= nirqd + 1;
    if (shut === 1'b1) nshut <= nshut + 1;
  end
  function [11:0] mv(input [4:0] c);
    mv = c[4] ? 12'h708 + c[3:0] * 12'h064 : 12'h384 + c[3:0] * 12'h032;
  endfunction
  function [15:0] dflt(input integer t);
    dflt = (t == 0) ? `LRS_DEF_CTL : (t == 1) ? `LRS_DEF_FS : `LRS_DEF_HIB;
  endfunction
  function [15:0] msk(input integer t);
    msk = (t == 0) ? `LRS_MASK_CTL : (t == 1) ? `LRS_MASK_FS : `LRS_MASK_HIB;
  endfunction
  task cyc(input integer n);
    repeat (n) @(posedge pclk);
  endtask
  task apb(input w, input [9:0] ix, input [1:0] lo, input [31:0] d);
    integer n;
    begin
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= {ix, lo};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
      if (n >= 20) `CHK(1'b0, 1'b1, "no ready")
    end
  endtask
  task wr(input [9:0] ix, input [31:0] d);
    apb(1, ix, 2'b00, d);
  endtask
  task rdc(input [9:0] ix, input [31:0] x);
    begin
      apb(0, ix, 2'b00, 0);
      `CHK(rd, x, "read data")
    end
  endtask
  task wst(input [1:0] s);
    integer n;
    begin
      n = 0;
      do begin
        apb(0, `LRS_IDX_STAT, 2'b00, 0);
        n++;
      end while (rd[1:0] !== s && n < 200);
      `CHK(rd[1:0], s, "state")
      cyc(4);
    end
  endtask
  task go(input [1:0] s);
    begin
      apb(0, `LRS_IDX_STAT, 2'b00, 0);
      if (rd[1:0] !== s) wr(`LRS_IDX_SYS, s == 2 ? 1 : 2);
      wst(s);
    end
  endtask
  task rst;
    begin
      presetn <= 0;
      cyc(5);
      presetn <= 1;
      cyc(3);
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial begin
    cyc(60000);
    errors++;
    give_verdict;
  end
  initial begin
    rst;
    for (k = 0; k < 2; k++) begin
      for (i = 0; i < 6; i++) begin
        rdc(`LRS_IDX_C_CTL + i, dflt(i % 3));
        v = $random(seed);
        wr(`LRS_IDX_C_CTL + i, v);
        rdc(`LRS_IDX_C_CTL + i, v & msk(i % 3));
        rd = i ? {d_sw, d_mv} : {c_sw, c_mv};
        if (i % 3 == 0) `CHK(rd[12:0], {v[14], v[14] ? 12'h000 : mv(v[4:0])}, "mode")
      end
      rst;
    end
    apb(0, 10'h000, 2'b00, 0);
    `CHK(e, 1'b1, "unmapped")
    apb(1, `LRS_IDX_C_FS, 2'b01, 32'hffff_ffff);
    `CHK(e, 1'b1, "misaligned")
    rdc(`LRS_IDX_C_FS, 0);
    $display("test registers done");
    wr(`LRS_IDX_D_CTL, 32'h0000_041b);
    cyc(6);
    `CHK(d_dis, 1'b0, "float")
    oo <= 1;
    cyc(6);
    `CHK(d_dis, 1'b1, "all off")
    wr(`LRS_IDX_D_CTL, 32'h0000_001b);
    wr(`LRS_IDX_C_FS, 32'h0000_0400);
    go(2);
    `CHK({c_on, d_on, d_dis}, 3'b101, "slot 1 and off")
    go(0);
    `CHK({c_on, c_dis}, 2'b01, "shutdown at off")
    wr(`LRS_IDX_C_FS, 32'h0000_3840);
    wr(`LRS_IDX_D_FS, 32'h0000_3c00);
    wr(`LRS_IDX_SYS, 1);
    k = 0;
    repeat (200) begin
      @(posedge pclk);
      if (d_on === 1'b1 && k == 0) `CHK(c_on, 1'b1, "slot order")
      if (d_on === 1'b1) k = 1;
    end
    wst(2);
    `CHK({c_on, d_on}, 2'b11, "active entry")
    for (i = 0; i < 8; i++) begin
      v = $random(seed);
      if (i < 4) v[4:0] = {i[1], {4{i[0]}}};
      wr(`LRS_IDX_D_CTL, v[4:0]);
      cyc(4);
      `CHK(d_mv, mv(v[4:0]), "voltage code")
    end
    wr(`LRS_IDX_D_CTL, 32'h0000_4000 | v[4:0]);
    cyc(4);
    `CHK({d_sw, d_mv}, 13'h1000, "switch mode")
    $display("test sequence done");
    for (i = 0; i < 4; i++) begin
      wr(`LRS_IDX_C_HIB, 32'h0000_1000 | (i << 8));
      if (i == 0) wr(`LRS_IDX_SYS, 4);
      else lp <= 3'b001 << (i - 1);
      cyc(6);
      `CHK(c_on, 1'b0, "hibernate off")
      wr(`LRS_IDX_SYS, 0);
      lp <= 0;
      cyc(6);
      `CHK(c_on, 1'b1, "hibernate exit")
    end
    v = $random(seed);
    wr(`LRS_IDX_C_HIB, v[4:0]);
    wr(`LRS_IDX_SYS, 4);
    cyc(6);
    `CHK(c_mv, mv(v[4:0]), "image voltage")
    wr(`LRS_IDX_SYS, 0);
    wr(`LRS_IDX_SYS, 2);
    k = 0;
    repeat (200) begin
      @(posedge pclk);
      if (c_on === 1'b0 && k == 0) `CHK(d_on, 1'b1, "shutdown order")
      if (c_on === 1'b0) k = 1;
    end
    `CHK({c_on, d_on, k[0]}, 3'b001, "off after shutdown")
    $display("test hibernate done");
    for (i = 0; i < 4; i++) begin
      go(0);
      wr(`LRS_IDX_C_FS, (i << 14) | 32'h0000_0400);
      go(2);
      k = nshut;
      v = nirq;
      fc <= 1;
      fd <= 1;
      cyc(6);
      fc <= 0;
      fd <= 0;
      cyc(4);
      `CHK(nirq, v + 1, "fault event")
      `CHK(nirqd, i + 1, "fault event d")
      `CHK(c_on, i == 0, "fault action")
      `CHK(nshut, k + (i >= 2), "system shutdown")
      if (i >= 2) rdc(`LRS_IDX_C_FS, 0);
    end
    $display("test faults done");
    give_verdict;
  end
endmodule // lrs_top_tb
bind lrs_top lrs_top_properties #(.SLOT_CYCLES(SLOT_CYCLES)) lrs_top_properties_inst (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .fault_c(fault_c), .others_off(others_off), .reg_c_on(reg_c_on), .reg_d_on(reg_d_on),
  .reg_c_discharge(reg_c_discharge), .reg_d_discharge(reg_d_discharge), .reg_c_irq(reg_c_irq),
  .reg_d_switch(reg_d_switch), .reg_c_mv(reg_c_mv), .reg_d_mv(reg_d_mv), .sys_shutdown(sys_shutdown));
